// *** osq_edge.sv ***
// Purpose: samples control inputs every 2 ms and pulses on falling edges
// Assumes: inputs synchronous to mclk_i; tick_i is the 0.1 ms strobe
// Notes:   a glitch shorter than the sample period may be missed by design
`default_nettype none
module osq_edge
  import osq_pkg::*;
(
  input  wire logic            mclk_i,
  input  wire logic            srst_i,
  input  wire logic            tick_i,
  input  wire logic [N_IN-1:0] pin_i,
  output logic      [N_IN-1:0] fall_o
);
  logic [4:0]      div_r, div_nxt;
  logic [N_IN-1:0] smp_r, smp_nxt;
  logic [N_IN-1:0] fall_r, fall_nxt;

  always_comb begin
    div_nxt  = div_r;
    smp_nxt  = smp_r;
    fall_nxt = '0;
    if (tick_i) begin
      if (div_r == 5'(SAMPLE_TICKS - 1)) begin
        div_nxt  = '0;
        smp_nxt  = pin_i;
        fall_nxt = smp_r & ~pin_i;
      end else begin
        div_nxt = div_r + 5'h01;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      div_r  <= '0;
      smp_r  <= '1; // inputs idle high through pull-ups
      fall_r <= '0;
    end else begin
      div_r  <= div_nxt;
      smp_r  <= smp_nxt;
      fall_r <= fall_nxt;
    end
  end
  assign fall_o = fall_r;
endmodule
`default_nettype wire

// *** osq_ext_ctl.sv ***
// Purpose: external controller on the control connector
// Assumes: press_i held across at least one 2 ms sample
// Notes:   lines have pull-ups, so a released line reads high
`default_nettype none
module osq_ext_ctl
  import osq_pkg::*;
(
  input  wire logic            mclk_i,
  input  wire logic [N_IN-1:0] press_i,
  output logic      [N_IN-1:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge mclk_i) begin
    pin_o <= ~press_i;
  end
endmodule
`default_nettype wire

// *** osq_pkg.sv ***
// Purpose: shared constants and types for the output sequencer control block
// Assumes: 40 MHz mclk_i, synchronous active-high reset
// Notes:   times are kept in their own unit and converted to cycle counts here
`default_nettype none
package osq_pkg;
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned TICK_NS       = 100_000;   // 0.1 ms step timer tick
  localparam int unsigned SAMPLE_NS     = 2_000_000; // 2 ms input sample period
  localparam int unsigned TICK_CYC      = (TICK_NS / 25);
  localparam int unsigned SAMPLE_TICKS  = SAMPLE_NS / TICK_NS;
  localparam logic [7:0]  MAX_STEPS     = 8'hff;
  localparam logic [23:0] MAX_STEP_TIME = 24'h98967f; // 9999999 ticks = 999.9999 s
  localparam logic [9:0]  MAX_JUMPS     = 10'h3e7;    // 999
  localparam int unsigned NUM_WAVES     = 16;
  localparam int unsigned WAVE_WORDS    = 4096;
  localparam int unsigned SAMPLE_W      = 15;
  localparam int unsigned NUM_SLOTS     = 30;
  localparam int unsigned PARAM_W       = 16;
  localparam int unsigned N_IN          = 7;
  // input bit positions
  localparam int unsigned IN_OFF  = 0;
  localparam int unsigned IN_ON   = 1;
  localparam int unsigned IN_STRT = 2;
  localparam int unsigned IN_STOP = 3;
  localparam int unsigned IN_HOLD = 4;
  localparam int unsigned IN_BR0  = 5;
  localparam int unsigned IN_BR1  = 6;
  typedef enum logic [1:0] {OP_CONST, OP_KEEP, OP_SWEEP} osq_op_t;
  typedef enum {ST_IDLE, ST_RUN, ST_HOLD} osq_state_t;
endpackage
`default_nettype wire

// *** osq_top.sv ***
// Purpose: output sequencer with external control I/O, protection and lock
// Assumes: one 40 MHz clock; step table loaded by software through the prog port
// Notes:   parameters are packed as dc, ac, freq, wave; one table per mode/range
//
// Contract
// - sequence length is 1 to 255 steps.
// - step time 0.1 ms to 999.9999 s, counted in 0.1 ms ticks.
// - each parameter per step is constant, keep, or linear sweep.
// - step holds dc, ac, frequency, waveform and two sync bits.
// - jump count 1 to 999 or infinite.
// - one sequence per mode and range; runs only with internal source.
// - hold freezes current values; start resumes from hold.
// - branch moves execution to a chosen target step.
// - all control inputs sampled once per 2 ms.
// - falling edges switch output off, on, start, stop, hold.
// - branch inputs 0 and 1 start their branch on a falling edge.
// - state outputs refreshed every 0.1 ms.
// - power and output status lines low when off, high when on.
// - limiter and busy lines high while active.
// - two sync lines show the running step's sync bits.
// - enable gates control inputs; state outputs always driven.
// - overvoltage or overcurrent forces output off and flags error.
// - internal fault forces output off and locks all operations.
// - over-temperature forces output off.
// - keylock ignores all actions except release and output off; only operator keys are blocked here, connector inputs still act.
// - power-on output setting turns output on after power-up.
// - recall of 30 slots rejected unless output is off.
// - waveform memory is 16 tables of 4096 fifteen-bit words.
`default_nettype none
module osq_top
  import osq_pkg::*;
(
  input  wire logic                mclk_i,
  input  wire logic                srst_i,
  // external control connector inputs (active falling edge)
  input  wire logic [N_IN-1:0]     ext_pin_i,
  input  wire logic                ext_en_i,
  // operator commands (one-cycle pulses)
  input  wire logic                key_out_on_i,
  input  wire logic                key_out_off_i,
  input  wire logic                key_start_i,
  input  wire logic                key_stop_i,
  input  wire logic                key_hold_i,
  input  wire logic                keylock_on_i,
  input  wire logic                keylock_off_i,
  input  wire logic                recall_req_i,
  input  wire logic [4:0]          recall_slot_i,
  // configuration
  input  wire logic                pwron_out_en_i,
  input  wire logic                mode_acdc_i,
  input  wire logic                range_200_i,
  input  wire logic                src_int_i,
  input  wire logic [7:0]          seq_len_i,
  input  wire logic [7:0]          jump_from_i,
  input  wire logic [7:0]          jump_to_i,
  input  wire logic [9:0]          jump_cnt_i,
  input  wire logic                jump_inf_i,
  input  wire logic [7:0]          br0_step_i,
  input  wire logic [7:0]          br1_step_i,
  // step table programming
  input  wire logic                prog_we_i,
  input  wire logic [1:0]          prog_tbl_i,
  input  wire logic [7:0]          prog_step_i,
  input  wire logic [4*PARAM_W-1:0] prog_val_i,
  input  wire logic [7:0]          prog_ops_i,
  input  wire logic [23:0]         prog_time_i,
  input  wire logic [1:0]          prog_sync_i,
  // waveform memory write and read address
  input  wire logic                wave_we_i,
  input  wire logic [3:0]          wave_wsel_i,
  input  wire logic [11:0]         wave_waddr_i,
  input  wire logic [SAMPLE_W-1:0] wave_wdata_i,
  input  wire logic [11:0]         wave_raddr_i,
  // monitors
  input  wire logic                ovp_i,
  input  wire logic                ocp_i,
  input  wire logic                int_fault_i,
  input  wire logic                otp_i,
  input  wire logic                limiter_i,
  input  wire logic                busy_i,
  // outputs
  output logic                     out_on_o,
  output logic                     err_o,
  output logic                     lock_o,
  output logic                     keylock_o,
  output logic                     recall_ok_o,
  output logic                     recall_rej_o,
  output logic [4:0]               recall_slot_o,
  output logic                     seq_run_o,
  output logic                     seq_hold_o,
  output logic [7:0]               seq_step_o,
  output logic [4*PARAM_W-1:0]     seq_val_o,
  output logic [SAMPLE_W-1:0]      wave_rdata_o,
  output logic                     st_pwr_o,
  output logic                     st_out_o,
  output logic                     st_lim_o,
  output logic                     st_busy_o,
  output logic [1:0]               st_sync_o
);
  ////////////////////////////////////////////////////////////////////////////
  // step table: one sequence per mode/range pair
  logic [4*PARAM_W-1:0] tbl_val  [4][256];
  logic [7:0]           tbl_ops  [4][256];
  logic [23:0]          tbl_time [4][256];
  logic [1:0]           tbl_sync [4][256];
  logic [1:0]           sel;

  assign sel = {mode_acdc_i, range_200_i};

  always_ff @(posedge mclk_i) begin
    if (prog_we_i) begin
      tbl_val[prog_tbl_i][prog_step_i]  <= prog_val_i;
      tbl_ops[prog_tbl_i][prog_step_i]  <= prog_ops_i;
      tbl_sync[prog_tbl_i][prog_step_i] <= prog_sync_i;
      tbl_time[prog_tbl_i][prog_step_i] <= (prog_time_i > MAX_STEP_TIME) ?
                                           MAX_STEP_TIME : prog_time_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // 0.1 ms timebase
  logic [11:0] tdiv_r, tdiv_nxt;
  logic        tick;

  assign tick = (tdiv_r == 12'(TICK_CYC - 1));
  always_comb begin
    tdiv_nxt = tick ? 12'h000 : tdiv_r + 12'h001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // external inputs and waveform memory
  logic [N_IN-1:0] fall;
  logic [N_IN-1:0] ext;

  osq_edge u_edge (
    .mclk_i (mclk_i),
    .srst_i (srst_i),
    .tick_i (tick),
    .pin_i  (ext_pin_i),
    .fall_o (fall)
  );

  osq_wave_mem u_wave (
    .mclk_i  (mclk_i),
    .we_i    (wave_we_i),
    .wsel_i  (wave_wsel_i),
    .waddr_i (wave_waddr_i),
    .wdata_i (wave_wdata_i),
    .rsel_i  (seq_val_o[3:0]),
    .raddr_i (wave_raddr_i),
    .rdata_o (wave_rdata_o)
  );

  assign ext = ext_en_i ? fall : '0;

  ////////////////////////////////////////////////////////////////////////////
  // output state, protection, lock, keylock, recall
  logic       on_r, on_nxt;
  logic       err_r, err_nxt;
  logic       lock_r, lock_nxt;
  logic       kl_r, kl_nxt;
  logic       pwrup_r, pwrup_nxt;
  logic       rok_r, rok_nxt;
  logic       rrej_r, rrej_nxt;
  logic [4:0] rslot_r, rslot_nxt;
  logic       op_ok;
  logic       trip;

  // lock wins over everything; keylock only blocks operator keys
  assign op_ok = ~lock_r & ~kl_r;
  assign trip  = ovp_i | ocp_i | int_fault_i | otp_i;

  always_comb begin
    on_nxt    = on_r;
    err_nxt   = err_r;
    lock_nxt  = lock_r | int_fault_i;
    kl_nxt    = kl_r;
    pwrup_nxt = 1'b0;
    rok_nxt   = 1'b0;
    rrej_nxt  = 1'b0;
    rslot_nxt = rslot_r;
    if (!lock_r) begin
      if (keylock_on_i) begin
        kl_nxt = 1'b1;
      end
      if (keylock_off_i) begin
        kl_nxt = 1'b0;
      end
      if (pwrup_r && pwron_out_en_i) begin
        on_nxt = 1'b1;
      end
      if ((op_ok && key_out_on_i) || ext[IN_ON]) begin
        on_nxt = 1'b1;
      end
      if (key_out_off_i || ext[IN_OFF]) begin
        on_nxt = 1'b0;
      end
      if (op_ok && recall_req_i) begin
        if (!on_r && recall_slot_i >= 5'h01 && recall_slot_i <= 5'(NUM_SLOTS)) begin
          rok_nxt   = 1'b1;
          rslot_nxt = recall_slot_i;
        end else begin
          rrej_nxt = 1'b1;
        end
      end
    end else if (recall_req_i) begin
      rrej_nxt = 1'b1;
    end
    // clear first so a fault in the same cycle as the clear still sets the flag
    if (on_r && key_out_on_i && op_ok) begin
      err_nxt = 1'b0;
    end
    if (ovp_i || ocp_i) begin
      err_nxt = 1'b1;
    end
    if (trip) begin
      on_nxt = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  osq_state_t           st_r, st_nxt;
  logic [7:0]           step_r, step_nxt;
  logic [23:0]          tcnt_r, tcnt_nxt;
  logic [9:0]           jcnt_r, jcnt_nxt;
  logic [4*PARAM_W-1:0] cur_r, cur_nxt;
  logic [4*PARAM_W-1:0] start_r, start_nxt;
  logic [7:0]           len;
  logic                 go, stop, hold, br0, br1;

  // lengths of zero are treated as one so the sequence always has a step
  assign len  = (seq_len_i == 8'h00) ? 8'h01 : seq_len_i;
  assign go   = src_int_i & ~lock_r & ((op_ok & key_start_i) | ext[IN_STRT]);
  assign stop = ~lock_r & ((op_ok & key_stop_i) | ext[IN_STOP]);
  assign hold = ~lock_r & ((op_ok & key_hold_i) | ext[IN_HOLD]);
  assign br0  = src_int_i & ~lock_r & ext[IN_BR0];
  assign br1  = src_int_i & ~lock_r & ext[IN_BR1];

  // linear interpolation of one parameter across the step
  function automatic logic [PARAM_W-1:0] osq_sweep(
    input logic [PARAM_W-1:0] a,
    input logic [PARAM_W-1:0] b,
    input logic [23:0]        el,
    input logic [23:0]        tot
  );
    logic signed [PARAM_W+1:0] d;
    logic signed [PARAM_W+25:0] p;
    d = $signed({2'b00, b}) - $signed({2'b00, a});
    p = d * $signed({1'b0, el});
    p = p / $signed({1'b0, (tot == 24'h0) ? 24'h1 : tot});
    osq_sweep = PARAM_W'($signed({2'b00, a}) + p);
  endfunction

  // value of every parameter at a given elapsed time in the step
  function automatic logic [4*PARAM_W-1:0] osq_eval(
    input logic [4*PARAM_W-1:0] prev,
    input logic [4*PARAM_W-1:0] tgt,
    input logic [7:0]           ops,
    input logic [23:0]          el,
    input logic [23:0]          tot
  );
    logic [4*PARAM_W-1:0] r;
    r = prev;
    for (int i = 0; i < 4; i++) begin
      unique case (osq_op_t'(ops[2*i +: 2]))
        OP_CONST: r[PARAM_W*i +: PARAM_W] = tgt[PARAM_W*i +: PARAM_W];
        OP_KEEP:  r[PARAM_W*i +: PARAM_W] = prev[PARAM_W*i +: PARAM_W];
        OP_SWEEP: r[PARAM_W*i +: PARAM_W] = osq_sweep(prev[PARAM_W*i +: PARAM_W],
                                                      tgt[PARAM_W*i +: PARAM_W], el, tot);
        default:  r[PARAM_W*i +: PARAM_W] = prev[PARAM_W*i +: PARAM_W];
      endcase
    end
    osq_eval = r;
  endfunction

  function automatic logic [7:0] osq_clip(input logic [7:0] s, input logic [7:0] n);
    osq_clip = (s >= n) ? 8'h00 : s;
  endfunction

  always_comb begin
    st_nxt    = st_r;
    step_nxt  = step_r;
    tcnt_nxt  = tcnt_r;
    jcnt_nxt  = jcnt_r;
    cur_nxt   = cur_r;
    start_nxt = start_r;
    unique case (st_r)
      ST_IDLE: begin
        if (go) begin
          st_nxt   = ST_RUN;
          step_nxt = 8'h00;
          tcnt_nxt = '0;
          jcnt_nxt = '0;
          start_nxt = cur_r;
        end
      end
      ST_RUN: begin
        if (tick) begin
          tcnt_nxt = tcnt_r + 24'h000001;
          cur_nxt  = osq_eval(start_r, tbl_val[sel][step_r], tbl_ops[sel][step_r],
                              tcnt_nxt, tbl_time[sel][step_r]);
          if (tcnt_nxt >= tbl_time[sel][step_r]) begin
            tcnt_nxt  = '0;
            start_nxt = cur_nxt;
            if (step_r == jump_from_i && (jump_inf_i || jcnt_r < jump_cnt_i)) begin
              // jump count saturates at 999; infinite bypasses the counter
              if (!jump_inf_i && jcnt_r < MAX_JUMPS) begin
                jcnt_nxt = jcnt_r + 10'h001;
              end
              step_nxt = osq_clip(jump_to_i, len);
            end else if (step_r + 8'h01 >= len) begin
              st_nxt = ST_IDLE;
            end else begin
              step_nxt = step_r + 8'h01;
            end
          end
        end
        if (hold) begin
          st_nxt = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (go) begin
          st_nxt = ST_RUN;
        end
      end
    endcase
    if (br0 || br1) begin
      st_nxt    = ST_RUN;
      step_nxt  = osq_clip(br0 ? br0_step_i : br1_step_i, len);
      tcnt_nxt  = '0;
      start_nxt = cur_r;
    end
    if (stop || !src_int_i || lock_r) begin
      st_nxt = ST_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state output lines, refreshed on the 0.1 ms tick
  logic       sp_r, sp_nxt;
  logic       so_r, so_nxt;
  logic       sl_r, sl_nxt;
  logic       sb_r, sb_nxt;
  logic [1:0] ss_r, ss_nxt;

  always_comb begin
    sp_nxt = sp_r;
    so_nxt = so_r;
    sl_nxt = sl_r;
    sb_nxt = sb_r;
    ss_nxt = ss_r;
    if (tick) begin
      sp_nxt = 1'b1;
      so_nxt = on_r;
      sl_nxt = limiter_i;
      sb_nxt = busy_i;
      ss_nxt = (st_r == ST_IDLE) ? 2'b00 : tbl_sync[sel][step_r];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      tdiv_r  <= '0;
      on_r    <= 1'b0;
      err_r   <= 1'b0;
      lock_r  <= 1'b0;
      kl_r    <= 1'b0;
      pwrup_r <= 1'b1;
      rok_r   <= 1'b0;
      rrej_r  <= 1'b0;
      rslot_r <= '0;
      st_r    <= ST_IDLE;
      step_r  <= '0;
      tcnt_r  <= '0;
      jcnt_r  <= '0;
      cur_r   <= '0;
      start_r <= '0;
      sp_r    <= 1'b0;
      so_r    <= 1'b0;
      sl_r    <= 1'b0;
      sb_r    <= 1'b0;
      ss_r    <= 2'b00;
    end else begin
      tdiv_r  <= tdiv_nxt;
      on_r    <= on_nxt;
      err_r   <= err_nxt;
      lock_r  <= lock_nxt;
      kl_r    <= kl_nxt;
      pwrup_r <= pwrup_nxt;
      rok_r   <= rok_nxt;
      rrej_r  <= rrej_nxt;
      rslot_r <= rslot_nxt;
      st_r    <= st_nxt;
      step_r  <= step_nxt;
      tcnt_r  <= tcnt_nxt;
      jcnt_r  <= jcnt_nxt;
      cur_r   <= cur_nxt;
      start_r <= start_nxt;
      sp_r    <= sp_nxt;
      so_r    <= so_nxt;
      sl_r    <= sl_nxt;
      sb_r    <= sb_nxt;
      ss_r    <= ss_nxt;
    end
  end

  assign out_on_o      = on_r;
  assign err_o         = err_r;
  assign lock_o        = lock_r;
  assign keylock_o     = kl_r;
  assign recall_ok_o   = rok_r;
  assign recall_rej_o  = rrej_r;
  assign recall_slot_o = rslot_r;
  assign seq_run_o     = (st_r == ST_RUN);
  assign seq_hold_o    = (st_r == ST_HOLD);
  assign seq_step_o    = step_r;
  assign seq_val_o     = cur_r;
  assign st_pwr_o      = sp_r;
  assign st_out_o      = so_r;
  assign st_lim_o      = sl_r;
  assign st_busy_o     = sb_r;
  assign st_sync_o     = ss_r;
endmodule
`default_nettype wire

// *** osq_top_bench.sv ***
// Purpose: self-checking bench for osq_top
// Assumes: 40 MHz clock, no count shortening
// Notes:   sampler starts idle high, so a press before the first 2 ms sample is a fall
`default_nettype none
module osq_top_bench
  import osq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int K_ON = 0, K_OFF = 1, K_STA = 2, K_HLD = 4, K_KLON = 5, K_KLOFF = 6;
  localparam int K_RCL = 7, K_PRG = 8, K_WAV = 9, K_OVP = 10, K_FLT = 12, K_OTP = 13;
  localparam logic [63:0] VA = 64'h0003_0032_0064_00c8;
  localparam logic [63:0] VB = 64'h0005_003c_0096_012c;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [13:0] kp = '0;
  logic [N_IN-1:0] press = '0;
  logic [N_IN-1:0] ext_pin_i;
  logic ext_en_i, pwron_out_en_i, mode_acdc_i, range_200_i, src_int_i, jump_inf_i;
  logic limiter_i, busy_i;
  wire  key_out_on_i, key_out_off_i, key_start_i, key_stop_i, key_hold_i, keylock_on_i;
  wire  keylock_off_i, recall_req_i, prog_we_i, wave_we_i, ovp_i, ocp_i, int_fault_i, otp_i;
  logic out_on_o, err_o, lock_o, keylock_o, recall_ok_o, recall_rej_o, seq_run_o;
  logic seq_hold_o, st_pwr_o, st_out_o, st_lim_o, st_busy_o;
  logic [4:0]  recall_slot_i, recall_slot_o;
  logic [7:0]  seq_len_i, jump_from_i, jump_to_i, br0_step_i, br1_step_i;
  logic [7:0]  prog_step_i, prog_ops_i, seq_step_o;
  logic [9:0]  jump_cnt_i;
  logic [1:0]  prog_tbl_i, prog_sync_i, st_sync_o;
  logic [63:0] prog_val_i, seq_val_o;
  logic [23:0] prog_time_i;
  logic [3:0]  wave_wsel_i;
  logic [11:0] wave_waddr_i, wave_raddr_i;
  logic [14:0] wave_wdata_i, wave_rdata_o;
  int          failures = 0;
  int          samples_checked = 0;
  int          cnt = 0;
  assign {otp_i, int_fault_i, ocp_i, ovp_i, wave_we_i, prog_we_i, recall_req_i, keylock_off_i,
          keylock_on_i, key_hold_i, key_stop_i, key_start_i, key_out_off_i, key_out_on_i} = kp;
  osq_top u_osq_top (.mclk_i, .srst_i, .ext_pin_i, .ext_en_i, .key_out_on_i, .key_out_off_i,
    .key_start_i, .key_stop_i, .key_hold_i, .keylock_on_i, .keylock_off_i, .recall_req_i,
    .recall_slot_i, .pwron_out_en_i, .mode_acdc_i, .range_200_i, .src_int_i, .seq_len_i,
    .jump_from_i, .jump_to_i, .jump_cnt_i, .jump_inf_i, .br0_step_i, .br1_step_i, .prog_we_i,
    .prog_tbl_i, .prog_step_i, .prog_val_i, .prog_ops_i, .prog_time_i, .prog_sync_i,
    .wave_we_i, .wave_wsel_i, .wave_waddr_i, .wave_wdata_i, .wave_raddr_i, .ovp_i, .ocp_i,
    .int_fault_i, .otp_i, .limiter_i, .busy_i, .out_on_o, .err_o, .lock_o, .keylock_o,
    .recall_ok_o, .recall_rej_o, .recall_slot_o, .seq_run_o, .seq_hold_o, .seq_step_o,
    .seq_val_o, .wave_rdata_o, .st_pwr_o, .st_out_o, .st_lim_o, .st_busy_o, .st_sync_o);
  osq_ext_ctl u_osq_ext_ctl (.mclk_i, .press_i(press), .pin_o(ext_pin_i));
  always #12.5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) cnt <= srst_i ? 0 : cnt + 1;
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // inputs move only on rising edges; checks land on the falling edge
  task automatic pulse(input int b);
    @(posedge mclk_i) kp[b] <= 1'b1;
    @(posedge mclk_i) kp <= '0;
    @(negedge mclk_i);
  endtask
  task automatic prog(input logic [7:0] st, input logic [63:0] v, input logic [7:0] op,
                      input logic [1:0] sy);
    @(posedge mclk_i);
    {prog_step_i, prog_val_i, prog_ops_i, prog_sync_i} <= {st, v, op, sy};
    pulse(K_PRG);
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  task automatic end_sim;
    if (failures == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    {pwron_out_en_i, mode_acdc_i, range_200_i, jump_inf_i, limiter_i, busy_i} = 6'h20;
    {jump_to_i, jump_cnt_i, br0_step_i, br1_step_i, prog_tbl_i} = '0;
    {wave_wsel_i, wave_waddr_i, wave_wdata_i, wave_raddr_i} = '0;
    {ext_en_i, src_int_i, jump_from_i, seq_len_i, prog_time_i} = {2'b11, 8'hff, 8'h02, 24'h3};
    {prog_step_i, prog_val_i, prog_ops_i, prog_sync_i, recall_slot_i} = {82'h0, 5'd30};
    repeat (2) @(posedge mclk_i);
    srst_i <= 1'b0;
    prog(8'h00, VA, 8'h00, 2'b01);
    chk(out_on_o, 1'b1);
    prog(8'h01, VB, 8'h01, 2'b10);
    pulse(K_STA);
    chk(seq_run_o, 1'b1);
    chk(seq_step_o, 8'h00);
    while (seq_step_o !== 8'h01 && cnt < 20000) idle(1);
    idle(4002);
    chk(seq_val_o, {VB[63:16], VA[15:0]});
    chk(st_sync_o, 2'b10);
    pulse(K_HLD);
    idle(13000);
    chk({seq_hold_o, seq_step_o}, 9'h101);
    pulse(K_STA);
    chk(seq_run_o, 1'b1);
    idle(13000);
    chk(seq_run_o, 1'b0);
    @(posedge mclk_i) {wave_wsel_i, wave_waddr_i, wave_raddr_i} <= {seq_val_o[3:0], 24'hffeffe};
    wave_wdata_i <= 15'h7abc;
    pulse(K_WAV);
    idle(2);
    chk(wave_rdata_o, 15'h7abc);
    pulse(K_ON);
    chk(out_on_o, 1'b1);
    pulse(K_RCL);
    chk({recall_rej_o, recall_ok_o}, 2'b10);
    pulse(K_OFF);
    pulse(K_RCL);
    chk({recall_rej_o, recall_ok_o}, 2'b01);
    pulse(K_KLON);
    pulse(K_ON);
    chk(out_on_o, 1'b0);
    pulse(K_KLOFF);
    pulse(K_ON);
    pulse(K_OVP);
    chk({out_on_o, err_o}, 2'b01);
    pulse(K_ON);
    pulse(K_OTP);
    chk(out_on_o, 1'b0);
    @(posedge mclk_i) {limiter_i, busy_i, press[IN_ON], press[IN_BR0]} <= 4'hf;
    while (out_on_o !== 1'b1 && cnt < 80010) idle(1);
    chk({out_on_o, seq_run_o, cnt > 79000}, 3'b111);
    chk({st_pwr_o, st_lim_o, st_busy_o}, 3'b111);
    idle(4002);
    chk(st_out_o, 1'b1);
    pulse(K_FLT);
    chk({lock_o, out_on_o}, 2'b10);
    pulse(K_ON);
    chk(out_on_o, 1'b0);
    end_sim();
  end
  initial begin
    repeat (95000) @(posedge mclk_i);
    failures++;
    end_sim();
  end
endmodule
`default_nettype wire

// *** osq_top_props.sv ***
// Purpose: port checker for osq_top
// Assumes: one clock, sync reset
// Notes:   status bounds allow one full 0.1 ms tick
`default_nettype none
module osq_top_props
  import osq_pkg::*;
(
  input wire logic               mclk_i,
  input wire logic               srst_i,
  input wire logic               key_out_on_i,
  input wire logic               key_out_off_i,
  input wire logic               recall_req_i,
  input wire logic               ovp_i,
  input wire logic               ocp_i,
  input wire logic               otp_i,
  input wire logic               int_fault_i,
  input wire logic               limiter_i,
  input wire logic               src_int_i,
  input wire logic               out_on_o,
  input wire logic               err_o,
  input wire logic               lock_o,
  input wire logic               keylock_o,
  input wire logic               recall_ok_o,
  input wire logic               recall_rej_o,
  input wire logic               seq_run_o,
  input wire logic               seq_hold_o,
  input wire logic [7:0]         seq_step_o,
  input wire logic [4*PARAM_W-1:0] seq_val_o,
  input wire logic               st_out_o,
  input wire logic               st_lim_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  wire prot = ovp_i | ocp_i | otp_i | int_fault_i;
  // lag counters stand in for a delay range longer than a tick
  logic [12:0] out_lag_r, lim_lag_r;
  always_ff @(posedge mclk_i) begin
    out_lag_r <= (srst_i || !out_on_o || st_out_o) ? 13'h0000 : out_lag_r + 13'h0001;
    lim_lag_r <= (srst_i || !limiter_i || st_lim_o) ? 13'h0000 : lim_lag_r + 13'h0001;
  end
  ////////////////////////////////////////////////////////////////
  property p_on; key_out_on_i && !key_out_off_i && !prot && !lock_o && !keylock_o
    |=> out_on_o; endproperty
  a_on: assert property (p_on) else $error("output on key ignored");
  property p_off; key_out_off_i |=> !out_on_o; endproperty
  a_off: assert property (p_off) else $error("output off key ignored");
  property p_prot; prot |=> !out_on_o; endproperty
  a_prot: assert property (p_prot) else $error("output on after fault");
  property p_err; ovp_i || ocp_i |=> err_o; endproperty
  a_err: assert property (p_err) else $error("error flag missing");
  property p_lock; int_fault_i |=> lock_o; endproperty
  a_lock: assert property (p_lock) else $error("lock missing");
  property p_locked; lock_o |=> lock_o && !out_on_o; endproperty
  a_locked: assert property (p_locked) else $error("lock left");
  property p_kl; keylock_o && recall_req_i |=> !recall_ok_o && !recall_rej_o; endproperty
  a_kl: assert property (p_kl) else $error("recall under keylock");
  property p_rcl; recall_req_i && out_on_o && !keylock_o |=> recall_rej_o && !recall_ok_o;
  endproperty
  a_rcl: assert property (p_rcl) else $error("recall while on");
  property p_hold; seq_hold_o ##1 seq_hold_o |-> $stable(seq_val_o) && $stable(seq_step_o);
  endproperty
  a_hold: assert property (p_hold) else $error("values moved in hold");
  property p_src; !src_int_i |=> !seq_run_o; endproperty
  a_src: assert property (p_src) else $error("run without source");
  property p_stout; out_lag_r < 13'h0fa2; endproperty
  a_stout: assert property (p_stout) else $error("output status late");
  property p_stlim; lim_lag_r < 13'h0fa2; endproperty
  a_stlim: assert property (p_stlim) else $error("limiter status late");
  c_resume: cover property (seq_hold_o ##1 seq_run_o);
  c_recall: cover property (recall_ok_o);
  c_lock: cover property (lock_o);
endmodule
bind osq_top osq_top_props u_osq_top_props (.mclk_i, .srst_i, .key_out_on_i, .key_out_off_i,
  .recall_req_i, .ovp_i, .ocp_i, .otp_i, .int_fault_i, .limiter_i, .src_int_i, .out_on_o,
  .err_o, .lock_o, .keylock_o, .recall_ok_o, .recall_rej_o, .seq_run_o, .seq_hold_o,
  .seq_step_o, .seq_val_o, .st_out_o, .st_lim_o);
`default_nettype wire

// *** osq_wave_mem.sv ***
// Purpose: arbitrary waveform storage, 16 tables of 4096 samples
// Assumes: one write port, one registered read port
// Notes:   read data appears one cycle after the address
`default_nettype none
module osq_wave_mem
  import osq_pkg::*;
(
  input  wire logic                mclk_i,
  input  wire logic                we_i,
  input  wire logic [3:0]          wsel_i,
  input  wire logic [11:0]         waddr_i,
  input  wire logic [SAMPLE_W-1:0] wdata_i,
  input  wire logic [3:0]          rsel_i,
  input  wire logic [11:0]         raddr_i,
  output logic      [SAMPLE_W-1:0] rdata_o
);
  logic [SAMPLE_W-1:0] mem [NUM_WAVES*WAVE_WORDS];
  logic [SAMPLE_W-1:0] rdata_r;

  always_ff @(posedge mclk_i) begin
    if (we_i) begin
      mem[{wsel_i, waddr_i}] <= wdata_i;
    end
    rdata_r <= mem[{rsel_i, raddr_i}];
  end
  assign rdata_o = rdata_r;
endmodule
`default_nettype wire
